/* File: rtl/charger_status_fault_protect_regs.vh */
`ifndef CHARGER_STATUS_FAULT_PROTECT_REGS_VH
`define CHARGER_STATUS_FAULT_PROTECT_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_INPUT_SOURCE 8'h00
`define OFS_THERMAL_SET 8'h04
`define OFS_SYSTEM_STATUS 8'h08
`define OFS_FAULT 8'h0C
`define OFS_CONTROL 8'h10
`define OFS_PROTECT_STATUS 8'h14

// ****************************************
// reset values
// ****************************************
`define RST_INPUT_LIMIT 3'h2
`define RST_THERMAL_SET 2'h3
`define RST_CHARGE_EN 1'h1
`define RST_BOOST_EN 1'h0

// ****************************************
// field codes
// ****************************************
`define CHG_FLT_NONE 2'h0
`define CHG_FLT_INPUT 2'h1
`define CHG_FLT_THERMAL 2'h2
`define CHG_FLT_TIMER 2'h3
`define PHASE_DONE 2'h3
`define PHASE_IDLE 2'h0
`define THERM_OK 3'h0

// ****************************************
// field positions
// ****************************************
`define CTRL_CHARGE_EN 0
`define CTRL_BOOST_EN 1
`define FLT_BOOST 6
`define FLT_BATT 3

// ****************************************
// timing, clock period and printed times
// ****************************************
`define CLK_PERIOD_NS 10
`define ALERT_PULSE_US 256
`define HICCUP_OFF_US 260
`define SHORT_OFF_MS 1
`define BLINK_HZ 1

`endif

/* File: rtl/charger_status_fault_protect.v */
// Function
// - stat pin low charging, released when done or idle, blinks 1Hz on fault.
// - every alert is one 256us pulse on the alert output.
// - source identified, good source, removal or overvoltage, done always alert.
// - a fault alerts and stays latched in fault register until read.
// - with an unread fault latched, only thermistor field changes and the status events above alert.
// - thermistor field is live, never latched.
// - first read gives latched faults, second consecutive read present ones.
// - input limit is lower of pin limit and register field, 111 is 3A.
// - limit pin above 1V enters input current regulation.
// - die temperature above selected 2-bit setting reduces charge current.
// - thermal regulation stops termination, halves timer, sets status bit.
// - thermal shutdown stops converter, charge fault 10, alert.
// - input overvoltage stops switching, charge fault 01, alert.
// - system overvoltage stops converter at once.
// - boost overcurrent opens reverse switch 260us then retries repeatedly.
// - boost overcurrent sets boost fault bit 6 and alerts.
// - boost bus overvoltage stops boost, sets boost fault, alerts.
// - battery overvoltage disables charging, sets battery fault, alerts.
// - battery below 2V: switch off 1ms, then 100mA; no discharge below 2.5V.
// - system overcurrent latches battery switch off until new source insertion.
// - thermistor fault shows in field, alerts, blinks stat when suspended.
// - termination sets charge status 11 and alerts.
//
// Implementation choices: register access over APB and the placing of the registers.
`include "charger_status_fault_protect_regs.vh"
`default_nettype none

module charger_status_fault_protect #(
  parameter ALERT_CYCLES = `ALERT_PULSE_US * 1000 / `CLK_PERIOD_NS,
  parameter HICCUP_CYCLES = `HICCUP_OFF_US * 1000 / `CLK_PERIOD_NS,
  parameter SHORT_CYCLES = `SHORT_OFF_MS * 1000000 / `CLK_PERIOD_NS,
  parameter BLINK_HALF_CYCLES = 500000000 / `BLINK_HZ / `CLK_PERIOD_NS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire source_identified,
  input wire good_source,
  input wire input_present,
  input wire input_overvoltage,
  input wire system_overvoltage,
  input wire thermal_shutdown,
  input wire safety_timer_expired,
  input wire [1:0] charge_phase,
  input wire [2:0] thermistor_fault,
  input wire [3:0] temp_above,
  input wire [2:0] input_limit_pin,
  input wire input_limit_above_1v,
  input wire boost_overcurrent,
  input wire boost_overvoltage,
  input wire battery_overvoltage,
  input wire battery_below_2v,
  input wire battery_below_2v5,
  input wire system_overcurrent,
  output reg stat_out,
  output reg stat_oe_n,
  output reg alert_n,
  output reg [2:0] input_limit_code,
  output reg current_regulation,
  output reg thermal_regulation,
  output reg termination_enable,
  output reg timer_half_rate,
  output reg converter_off,
  output reg charge_disable,
  output reg boost_run,
  output reg reverse_blocking_switch_on,
  output reg battery_switch_on,
  output reg low_current_charge
);

  // ****************************************
  // helpers
  // ****************************************
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  function [2:0] min3;
    input [2:0] a;
    input [2:0] b;
    begin
      min3 = (a < b) ? a : b;
    end
  endfunction

  localparam [1:0] HC_ON = 2'b01;
  localparam [1:0] HC_OFF = 2'b10;
  localparam [2:0] BS_NORM = 3'b001;
  localparam [2:0] BS_OFF = 3'b010;
  localparam [2:0] BS_LOW = 3'b100;

  // ****************************************
  // software registers
  // ****************************************
  reg [2:0] limit_field_q;
  reg [1:0] therm_set_q;
  reg chg_en_q;
  reg boost_en_q;
  reg [1:0] flt_chg_q;
  reg flt_boost_q;
  reg flt_batt_q;
  reg boost_lock_q;
  reg [1:0] hc_q;
  reg [2:0] bs_q;
  reg sysoc_q;
  wire setup = psel & ~penable;
  wire done = psel & penable & pready;
  wire wr = done & pwrite;
  wire rd_fault = done & ~pwrite & hit(paddr, `OFS_FAULT);

  // live fault conditions
  reg [1:0] live_chg;
  always @* begin
    if (thermal_shutdown)
      live_chg = `CHG_FLT_THERMAL;
    else if (input_overvoltage)
      live_chg = `CHG_FLT_INPUT;
    else if (safety_timer_expired)
      live_chg = `CHG_FLT_TIMER;
    else
      live_chg = `CHG_FLT_NONE;
  end
  wire live_boost = boost_overcurrent | boost_overvoltage;
  wire [7:0] fault_view = {1'b0, flt_boost_q, flt_chg_q, flt_batt_q,
                           thermistor_fault};
  wire [7:0] sys_view = {2'h0, charge_phase, 2'h0, thermal_regulation,
                         current_regulation};
  wire [7:0] prot_view = {hc_q == HC_OFF, bs_q != BS_NORM, sysoc_q,
                          boost_lock_q, 1'b0, input_limit_code};

  // read data mux
  reg [7:0] rmux;
  reg rvalid;
  always @* begin
    rvalid = 1'b1;
    case (1'b1)
      hit(paddr, `OFS_INPUT_SOURCE): rmux = {5'h00, limit_field_q};
      hit(paddr, `OFS_THERMAL_SET): rmux = {6'h00, therm_set_q};
      hit(paddr, `OFS_SYSTEM_STATUS): rmux = sys_view;
      hit(paddr, `OFS_FAULT): rmux = fault_view;
      hit(paddr, `OFS_CONTROL): rmux = {6'h00, boost_en_q, chg_en_q};
      hit(paddr, `OFS_PROTECT_STATUS): rmux = prot_view;
      default: begin
        rmux = 8'h00;
        rvalid = 1'b0;
      end
    endcase
  end

  // apb answer: data prepared in setup, ready in first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : {24'h000000, rmux};
      pready <= 1'b1;
      pslverr <= ~rvalid;
    end else if (done) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // writable registers, taken at the completing access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_field_q <= `RST_INPUT_LIMIT;
      therm_set_q <= `RST_THERMAL_SET;
      chg_en_q <= `RST_CHARGE_EN;
      boost_en_q <= `RST_BOOST_EN;
    end else if (wr) begin
      if (hit(paddr, `OFS_INPUT_SOURCE))
        limit_field_q <= pwdata[2:0];
      if (hit(paddr, `OFS_THERMAL_SET))
        therm_set_q <= pwdata[1:0];
      if (hit(paddr, `OFS_CONTROL)) begin
        chg_en_q <= pwdata[`CTRL_CHARGE_EN];
        boost_en_q <= pwdata[`CTRL_BOOST_EN];
      end
    end
  end

  // ****************************************
  // fault latch
  // ****************************************
  wire latched_any = flt_boost_q | flt_batt_q | (flt_chg_q != `CHG_FLT_NONE);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_chg_q <= `CHG_FLT_NONE;
      flt_boost_q <= 1'b0;
      flt_batt_q <= 1'b0;
    end else if (rd_fault) begin
      // read reloads the latch with present status
      flt_chg_q <= live_chg;
      flt_boost_q <= live_boost;
      flt_batt_q <= battery_overvoltage;
    end else begin
      if (flt_chg_q == `CHG_FLT_NONE)
        flt_chg_q <= live_chg;
      if (live_boost)
        flt_boost_q <= 1'b1;
      if (battery_overvoltage)
        flt_batt_q <= 1'b1;
    end
  end

  // ****************************************
  // event detection
  // ****************************************
  reg [8:0] prev_q;
  reg [2:0] therm_prev_q;
  reg [1:0] phase_prev_q;
  wire [8:0] cur = {source_identified, good_source, input_overvoltage,
                    thermal_shutdown, safety_timer_expired,
                    boost_overcurrent, boost_overvoltage,
                    battery_overvoltage, input_present};
  wire [8:0] rise = cur & ~prev_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 9'h000;
      therm_prev_q <= `THERM_OK;
      phase_prev_q <= `PHASE_IDLE;
    end else begin
      prev_q <= cur;
      therm_prev_q <= thermistor_fault;
      phase_prev_q <= charge_phase;
    end
  end
  wire status_evt = rise[8] | rise[7] | rise[6] | (prev_q[0] & ~cur[0]) |
    ((charge_phase == `PHASE_DONE) & (phase_prev_q != `PHASE_DONE));
  // other faults alert only with nothing latched
  wire fault_evt = (|rise[5:1]) & ~latched_any;
  wire therm_evt = thermistor_fault != therm_prev_q;
  wire alert_evt = status_evt | fault_evt | therm_evt;

  // ****************************************
  // alert pulse
  // ****************************************
  reg [14:0] alert_cnt_q;
  // fixed width low pulse, events inside a pulse merge into it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_cnt_q <= 15'h0000;
      alert_n <= 1'b1;
    end else if (alert_cnt_q != 15'h0000) begin
      alert_cnt_q <= alert_cnt_q - 15'h0001;
      alert_n <= (alert_cnt_q == 15'h0001);
    end else if (alert_evt) begin
      alert_cnt_q <= ALERT_CYCLES[14:0];
      alert_n <= 1'b0;
    end
  end

  // ****************************************
  // regulation and converter control
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_limit_code <= `RST_INPUT_LIMIT;
      current_regulation <= 1'b0;
      thermal_regulation <= 1'b0;
      termination_enable <= 1'b1;
      timer_half_rate <= 1'b0;
      converter_off <= 1'b0;
      charge_disable <= 1'b0;
    end else begin
      // lower of pin and register limit
      input_limit_code <= min3(input_limit_pin, limit_field_q);
      current_regulation <= input_limit_above_1v;
      thermal_regulation <= temp_above[therm_set_q];
      termination_enable <= ~temp_above[therm_set_q] &
                            ~input_limit_above_1v;
      timer_half_rate <= temp_above[therm_set_q] | input_limit_above_1v;
      converter_off <= thermal_shutdown | input_overvoltage |
                       system_overvoltage;
      charge_disable <= battery_overvoltage | ~chg_en_q;
    end
  end

  // ****************************************
  // boost overvoltage exit
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_lock_q <= 1'b0;
      boost_run <= 1'b0;
    end else begin
      // leave boost, rearmed when software clears boost enable
      if (boost_overvoltage & boost_run)
        boost_lock_q <= 1'b1;
      else if (~boost_en_q)
        boost_lock_q <= 1'b0;
      boost_run <= boost_en_q & ~boost_lock_q & ~boost_overvoltage;
    end
  end

  // ****************************************
  // boost overcurrent hiccup
  // ****************************************
  reg [14:0] hc_cnt_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hc_q <= HC_ON;
      hc_cnt_q <= 15'h0000;
      reverse_blocking_switch_on <= 1'b1;
    end else begin
      case (hc_q)
        HC_ON: begin
          // open the switch for the off time
          if (boost_overcurrent) begin
            hc_q <= HC_OFF;
            hc_cnt_q <= HICCUP_CYCLES[14:0];
            reverse_blocking_switch_on <= 1'b0;
          end
        end
        HC_OFF: begin
          if (hc_cnt_q == 15'h0001) begin
            hc_q <= HC_ON;
            reverse_blocking_switch_on <= 1'b1;
          end
          hc_cnt_q <= hc_cnt_q - 15'h0001;
        end
        default: begin
          hc_q <= HC_ON;
          reverse_blocking_switch_on <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // battery short and system overcurrent
  // ****************************************
  reg [16:0] bs_cnt_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bs_q <= BS_NORM;
      bs_cnt_q <= 17'h00000;
    end else begin
      case (bs_q)
        BS_NORM: begin
          if (battery_below_2v) begin
            bs_q <= BS_OFF;
            bs_cnt_q <= SHORT_CYCLES[16:0];
          end
        end
        BS_OFF: begin
          // back on at low current after the off time
          if (bs_cnt_q == 17'h00001)
            bs_q <= BS_LOW;
          bs_cnt_q <= bs_cnt_q - 17'h00001;
        end
        BS_LOW: begin
          if (~battery_below_2v5)
            bs_q <= BS_NORM;
        end
        default: bs_q <= BS_NORM;
      endcase
    end
  end

  // latch cleared only by a source insertion, set wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sysoc_q <= 1'b0;
    else if (system_overcurrent)
      sysoc_q <= 1'b1;
    else if (rise[0])
      sysoc_q <= 1'b0;
  end

  // battery switch and low current charge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      battery_switch_on <= 1'b1;
      low_current_charge <= 1'b0;
    end else begin
      // never discharge a battery under 2.5V
      battery_switch_on <= ~sysoc_q & (bs_q != BS_OFF) &
        ~(battery_below_2v5 & ~input_present);
      low_current_charge <= (bs_q == BS_LOW);
    end
  end

  // ****************************************
  // charge state pin
  // ****************************************
  reg [25:0] blink_cnt_q;
  reg blink_q;
  wire charging = chg_en_q & ((charge_phase != `PHASE_IDLE) &
                              (charge_phase != `PHASE_DONE));
  wire suspended = chg_en_q & input_present &
    ((live_chg != `CHG_FLT_NONE) | system_overvoltage |
     (thermistor_fault != `THERM_OK));
  // half period divider, 50 percent duty
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_q <= 26'h0000000;
      blink_q <= 1'b0;
    end else if (!suspended) begin
      blink_cnt_q <= 26'h0000000;
      blink_q <= 1'b0;
    end else if (blink_cnt_q == BLINK_HALF_CYCLES[25:0] - 26'h0000001) begin
      blink_cnt_q <= 26'h0000000;
      blink_q <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 26'h0000001;
    end
  end

  // open drain, enable low pulls the pin low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_out <= 1'b0;
      stat_oe_n <= 1'b1;
    end else begin
      stat_out <= 1'b0;
      if (suspended)
        stat_oe_n <= blink_q;
      else
        stat_oe_n <= ~charging;
    end
  end

endmodule

`default_nettype wire

/* File: testbench/charger_status_fault_protect_sva.sv */
`default_nettype none
module charger_fault_sva #(
  parameter int ALERT_CYCLES = 16,
  parameter int HICCUP_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic alert_n,
  input wire logic input_overvoltage,
  input wire logic system_overvoltage,
  input wire logic thermal_shutdown,
  input wire logic battery_overvoltage,
  input wire logic system_overcurrent,
  input wire logic boost_overcurrent,
  input wire logic input_limit_above_1v,
  input wire logic [2:0] thermistor_fault,
  input wire logic [2:0] input_limit_pin,
  input wire logic [2:0] input_limit_code,
  input wire logic current_regulation,
  input wire logic thermal_regulation,
  input wire logic termination_enable,
  input wire logic timer_half_rate,
  input wire logic converter_off,
  input wire logic charge_disable,
  input wire logic reverse_blocking_switch_on,
  input wire logic battery_switch_on
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] low_q;
  logic [15:0] off_q;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ****************************************
  // span counters for pulse and switch-off lengths
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_q <= 16'h0000;
      off_q <= 16'h0000;
    end else begin
      low_q <= alert_n ? 16'h0000 : low_q + 16'h0001;
      off_q <= reverse_blocking_switch_on ? 16'h0000 : off_q + 16'h0001;
    end
  end

  // alert must start within a few edges of its cause
  sequence alert_soon;
    ##[1:3] !alert_n;
  endsequence

  alert_width_a: assert property (
    $rose(alert_n) |-> low_q == ALERT_CYCLES) else $error("alert width");
  ovp_alert_a: assert property (
    $rose(input_overvoltage) && alert_n |-> alert_soon)
    else $error("no alert on input overvoltage");
  therm_alert_a: assert property (
    thermistor_fault != $past(thermistor_fault) && alert_n |-> alert_soon)
    else $error("no alert on thermistor change");
  conv_stop_a: assert property (
    input_overvoltage || system_overvoltage || thermal_shutdown
    |=> converter_off) else $error("converter not stopped");
  batt_ovp_a: assert property (
    battery_overvoltage |=> charge_disable) else $error("charge not off");
  limit_min_a: assert property (
    1'b1 |=> input_limit_code <= $past(input_limit_pin))
    else $error("limit above pin");
  limit_reg_a: assert property (
    input_limit_above_1v |=> current_regulation)
    else $error("no current regulation");
  therm_reg_a: assert property (
    thermal_regulation |-> !termination_enable && timer_half_rate)
    else $error("thermal regulation effects");
  hiccup_off_a: assert property (
    boost_overcurrent && reverse_blocking_switch_on
    |=> !reverse_blocking_switch_on) else $error("switch not opened");
  hiccup_len_a: assert property (
    $rose(reverse_blocking_switch_on) |-> off_q == HICCUP_CYCLES)
    else $error("hiccup off time");
  sysoc_off_a: assert property (
    system_overcurrent |-> ##2 !battery_switch_on)
    else $error("battery switch not off");
endmodule

bind charger_status_fault_protect charger_fault_sva #(
  .ALERT_CYCLES(ALERT_CYCLES),
  .HICCUP_CYCLES(HICCUP_CYCLES)
) sva_i (.*);
`default_nettype wire

/* File: testbench/host_model.sv */
`default_nettype none
module host_model (
  input wire logic pclk,
  input wire logic presetn,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [7:0] paddr,
  output var logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic alert_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int pulses = 0;
  int width = 0;
  int run_q = 0;

  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // count alert pulses and keep the last width
  always @(posedge pclk) begin
    if (alert_n === 1'b0)
      run_q <= run_q + 1;
    else if (run_q != 0) begin
      pulses <= pulses + 1;
      width <= run_q;
      run_q <= 0;
    end
  end

  // one bus transfer, held until ready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, rd_e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic source_identified = 1'b0, good_source = 1'b0;
  logic input_present = 1'b0, input_overvoltage = 1'b0;
  logic system_overvoltage = 1'b0, thermal_shutdown = 1'b0;
  logic safety_timer_expired = 1'b0, boost_overcurrent = 1'b0;
  logic boost_overvoltage = 1'b0, battery_overvoltage = 1'b0;
  logic battery_below_2v = 1'b0, battery_below_2v5 = 1'b0;
  logic system_overcurrent = 1'b0, input_limit_above_1v = 1'b0;
  logic [1:0] charge_phase = 2'h0;
  logic [2:0] thermistor_fault = 3'h0, input_limit_pin = 3'h7;
  logic [3:0] temp_above = 4'h0;
  logic [2:0] input_limit_code;
  logic stat_out, stat_oe_n, alert_n, current_regulation;
  logic thermal_regulation, termination_enable, timer_half_rate;
  logic converter_off, charge_disable, boost_run, low_current_charge;
  logic reverse_blocking_switch_on, battery_switch_on;
  int mismatches = 0;
  int checks_done = 0;
  int lows;

  charger_status_fault_protect #(
    .ALERT_CYCLES(16),
    .HICCUP_CYCLES(20),
    .SHORT_CYCLES(30),
    .BLINK_HALF_CYCLES(8)
  ) dut (.*);
  host_model h (.*);

  // 100 MHz clock
  always #5 pclk = ~pclk;

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    h.xfer(1'b1, a, d, rd_v, rd_e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    h.xfer(1'b0, a, 32'h0, rd_v, rd_e);
    chk(rd_v, e);
  endtask

  // count pulses raised by the stimulus just applied
  task automatic alerts(input int n);
    int b;
    b = h.pulses;
    cyc(30);
    chk(h.pulses - b, n);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #100us;
    mismatches++;
    end_of_test();
  end

  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    rdchk(8'h00, 32'h2);
    rdchk(8'h04, 32'h3);
    rdchk(8'h10, 32'h1);
    rdchk(8'h18, 32'h0);
    chk(rd_e, 1'b1);
    input_limit_pin <= 3'h4;
    wr(8'h00, 32'h7);
    cyc(2);
    chk(input_limit_code, 32'h4);
    wr(8'h00, 32'h1);
    cyc(2);
    chk(input_limit_code, 32'h1);
    input_present <= 1'b1;
    source_identified <= 1'b1;
    alerts(1);
    chk(h.width, 32'h10);
    good_source <= 1'b1;
    alerts(1);
    charge_phase <= 2'h2;
    input_limit_above_1v <= 1'b1;
    temp_above <= 4'hF;
    cyc(3);
    chk(stat_oe_n, 1'b0);
    rdchk(8'h08, 32'h23);
    input_limit_above_1v <= 1'b0;
    temp_above <= 4'h0;
    input_overvoltage <= 1'b1;
    alerts(1);
    lows = 0;
    repeat (32) begin
      @(posedge pclk);
      lows += (stat_oe_n === 1'b0);
    end
    chk(lows, 32'h10);
    thermal_shutdown <= 1'b1;
    alerts(0);
    thermistor_fault <= 3'h2;
    alerts(1);
    input_overvoltage <= 1'b0;
    thermal_shutdown <= 1'b0;
    thermistor_fault <= 3'h0;
    alerts(1);
    rdchk(8'h0C, 32'h10);
    rdchk(8'h0C, 32'h0);
    thermal_shutdown <= 1'b1;
    alerts(1);
    thermal_shutdown <= 1'b0;
    rdchk(8'h0C, 32'h20);
    rdchk(8'h0C, 32'h0);
    charge_phase <= 2'h3;
    alerts(1);
    chk(stat_oe_n, 1'b1);
    rdchk(8'h08, 32'h30);
    wr(8'h10, 32'h3);
    boost_overcurrent <= 1'b1;
    alerts(1);
    boost_overcurrent <= 1'b0;
    cyc(25);
    chk(reverse_blocking_switch_on, 1'b1);
    rdchk(8'h0C, 32'h40);
    rdchk(8'h0C, 32'h0);
    battery_overvoltage <= 1'b1;
    alerts(1);
    chk(charge_disable, 1'b1);
    battery_overvoltage <= 1'b0;
    rdchk(8'h0C, 32'h8);
    rdchk(8'h0C, 32'h0);
    boost_overvoltage <= 1'b1;
    alerts(1);
    chk(boost_run, 1'b0);
    boost_overvoltage <= 1'b0;
    rdchk(8'h0C, 32'h40);
    battery_below_2v5 <= 1'b1;
    battery_below_2v <= 1'b1;
    cyc(3);
    chk(battery_switch_on, 1'b0);
    battery_below_2v <= 1'b0;
    cyc(35);
    chk(battery_switch_on, 1'b1);
    chk(low_current_charge, 1'b1);
    battery_below_2v5 <= 1'b0;
    cyc(3);
    chk(low_current_charge, 1'b0);
    system_overcurrent <= 1'b1;
    system_overvoltage <= 1'b1;
    cyc(2);
    system_overcurrent <= 1'b0;
    system_overvoltage <= 1'b0;
    cyc(20);
    chk(battery_switch_on, 1'b0);
    input_present <= 1'b0;
    cyc(2);
    input_present <= 1'b1;
    cyc(3);
    chk(battery_switch_on, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
